// ### design/cpr_regs.sv
/*
 * Programmer register set of an 8-bit CPU: working byte, index pair,
 * stack top pointer, fetch pointer and flag word, with reset vector
 * load, interrupt and break entry, interrupt return, wait and stop.
 * Assumes an instruction sequencer drives the request ports, memory
 * returns read data combinationally, and software peeks and pokes the
 * registers over an Avalon-MM slave with waitrequest.
 */
`timescale 1ns/10ps

// Notes on behaviour
// - 8-bit working register feeds and takes ALU
// - 16-bit index pair from upper and lower byte
// - Stack pointer resets to 00FF
// - Low-byte preset forces FF, high kept
// - Push decrements, pull increments stack pointer
// - Fetch pointer increments, or loads jump target
// - Reset loads fetch pointer from FFFE/FFFF
// - Flag bits 6 and 5 always read one
// - Overflow flag on signed overflow, signed branches
// - Half carry from bit 3; decimal adjust
// - Mask blocks interrupts; set by reset, clear op
// - Stack registers, then set mask, then vector
// - Upper index byte never stacked by interrupts
// - Interrupt return pulls registers including mask
// - Highest priority pending request served first
// - Negative flag equals result bit 7
// - Zero flag when result is 00
// - Carry on add carry-out or subtract borrow
// - Wait clears mask, stops clock until interrupt
// - Stop likewise, but only the external request wakes it; clock resumes after stabilisation delay
// - Break forces trap opcode, loads break vector
// - Break at instruction end; return needs withdrawal
module cpr_regs import cpr_pkg::*; (
    input wire logic clk, // 20 MHz clock
    input wire logic rst, // Async reset, active high
    input wire logic a_we, // Write working register
    input wire logic [7:0] a_wd, // Working register data
    input wire logic h_we, // Write upper index byte
    input wire logic [7:0] h_wd, // Upper index data
    input wire logic x_we, // Write lower index byte
    input wire logic [7:0] x_wd, // Lower index data
    input wire logic sp_we, // Write stack pointer
    input wire logic [15:0] sp_wd, // Stack pointer data
    input wire logic sp_low_preset, // Stack low byte preset op
    input wire logic pc_we, // Load fetch pointer target
    input wire logic [15:0] pc_wd, // Fetch pointer target
    input wire logic pc_inc, // Fetch done, advance pointer
    input wire logic alu_go, // Apply ALU result and flags
    input wire cpr_alu_op_t alu_op, // ALU operation
    input wire logic [7:0] alu_a, // ALU first operand
    input wire logic [7:0] alu_b, // ALU second operand
    input wire logic alu_to_a, // ALU result into working reg
    input wire logic [7:0] flag_en, // Per-flag update enables
    input wire logic flag_we, // Write whole flag word
    input wire logic [7:0] flag_wd, // Flag word data
    input wire logic mask_clear_op, // Clear interrupt mask
    input wire logic mask_set_op, // Set interrupt mask
    input wire logic stk_push, // Push one byte
    input wire logic [7:0] stk_wdata, // Byte to push
    input wire logic stk_pull, // Pull one byte
    input wire logic instr_done, // Last cycle of instruction
    input wire logic interrupt_return_op, // Start interrupt return
    input wire logic wait_op, // Enter wait
    input wire logic stop_op, // Enter stop
    input wire logic [NUM_IRQ-1:0] irq_req, // Requests, bit 0 highest
    input wire logic brk_req, // Break request level
    input wire logic brk_match, // Break address match pulse
    input wire logic monitor_mode, // Monitor mode select
    input wire logic [7:0] mem_rdata, // Memory read data
    output logic [15:0] mem_addr, // Memory address
    output logic mem_rd, // Memory read strobe
    output logic mem_wr, // Memory write strobe
    output logic [7:0] mem_wdata, // Memory write data
    output logic [7:0] a_q, // Working register
    output logic [15:0] hx_q, // Index pair
    output logic [15:0] sp_q, // Stack pointer
    output logic [15:0] pc_q, // Fetch pointer
    output logic [7:0] flag_q, // Flag word
    output logic [7:0] alu_res, // ALU result
    output logic [7:0] stk_rdata, // Last byte pulled by stk_pull
    output logic signed_lt, // Signed less-than condition
    output logic signed_le, // Signed not-greater condition
    output logic busy, // Sequence owns memory
    output logic cpu_clk_en, // CPU clock running
    output logic ir_trap_load, // Put trap opcode in IR
    output logic in_break, // Inside break routine
    output logic irq_ack, // Interrupt vector fetch pulse
    output logic [2:0] irq_ack_id, // Serviced request index
    input wire logic [2:0] avs_address, // Word index
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest // Stall
);
    cpr_state_t state_reg, state_next;
    logic [7:0] a_reg, a_next, h_reg, h_next, x_reg, x_next;
    logic [15:0] sp_reg, sp_next, pc_reg, pc_next;
    logic [7:0] flg_reg, flg_next;
    logic [2:0] cnt_reg, cnt_next;
    logic [12:0] stab_reg, stab_next;
    logic [15:0] vec_reg, vec_next;
    logic [2:0] id_reg, id_next;
    logic brk_reg, brk_next;
    logic [7:0] pull_reg;
    logic acc_reg;
    logic [31:0] rdata_reg;
    logic [7:0] fu_res;
    logic fu_v, fu_h, fu_n, fu_z, fu_c;
    logic [2:0] irq_id;
    logic [15:0] irq_vec;
    logic [7:0] push_byte;

    wire run = (state_reg == ST_RUN);
    wire mask = flg_reg[FLG_I];
    wire [7:0] flg_rd = flg_reg | FLG_FIXED;
    wire irq_any = |irq_req;
    wire brk_take = instr_done && (brk_req || brk_match);
    wire irq_take = instr_done && !mask && irq_any;
    wire ret_go = run && interrupt_return_op;
    wire last_byte = (cnt_reg == STACK_BYTES - 3'h1);
    wire pull_end = (state_reg == ST_PULL) && last_byte;
    wire rebreak = pull_end && brk_reg && brk_req;
    wire bus_req = avs_read || avs_write;
    wire bus_wr = avs_write && acc_reg;
    wire wr_a = bus_wr && avs_address == IDX_WORK;
    wire wr_hx = bus_wr && avs_address == IDX_INDEX;
    wire wr_sp = bus_wr && avs_address == IDX_STACK;
    wire wr_pc = bus_wr && avs_address == IDX_FETCH;
    wire wr_flg = bus_wr && avs_address == IDX_FLAG;
    wire run_push = run && stk_push;
    wire run_pull = run && stk_pull && !stk_push;
    wire [15:0] brk_vec = monitor_mode ? VEC_BREAK_MON : VEC_BREAK;

    cpr_flag_unit u_flag (
        .opa(alu_a),
        .opb(alu_b),
        .cin(flg_reg[FLG_C]),
        .hin(flg_reg[FLG_H]),
        .op(alu_op),
        .res(fu_res),
        .v(fu_v),
        .h(fu_h),
        .n(fu_n),
        .z(fu_z),
        .c(fu_c)
    );

    // Lowest index wins among pending requests
    always_comb begin
        irq_id = 3'h0;
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (irq_req[i]) begin
                irq_id = 3'(i);
            end
        end
        irq_vec = VEC_IRQ_TOP - {12'h000, irq_id, 1'b0};
    end

    // Stacking order: fetch low, fetch high, index low, work, flags
    always_comb begin
        case (cnt_reg)
            3'h0: push_byte = pc_reg[7:0];
            3'h1: push_byte = pc_reg[15:8];
            3'h2: push_byte = x_reg;
            3'h3: push_byte = a_reg;
            default: push_byte = flg_rd;
        endcase
    end

    assign mem_rd = (state_reg == ST_VEC_HI) || (state_reg == ST_VEC_LO)
        || (state_reg == ST_IVEC_HI) || (state_reg == ST_IVEC_LO)
        || (state_reg == ST_PULL) || run_pull;
    assign mem_wr = (state_reg == ST_PUSH) || run_push;
    assign mem_wdata = (state_reg == ST_PUSH) ? push_byte : stk_wdata;

    always_comb begin
        case (state_reg)
            ST_VEC_HI: mem_addr = VEC_RESET_HI;
            ST_VEC_LO: mem_addr = VEC_RESET_LO;
            ST_IVEC_HI: mem_addr = vec_reg;
            ST_IVEC_LO: mem_addr = vec_reg + 16'h0001;
            ST_PULL: mem_addr = sp_reg + 16'h0001;
            ST_RUN: mem_addr = run_pull ? sp_reg + 16'h0001 : sp_reg;
            default: mem_addr = sp_reg;
        endcase
    end

    // Sequencing of reset, entry, return and low-power states
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        stab_next = stab_reg;
        vec_next = vec_reg;
        id_next = id_reg;
        brk_next = brk_reg;
        case (state_reg)
            ST_VEC_HI: state_next = ST_VEC_LO;
            ST_VEC_LO: state_next = ST_RUN;
            ST_RUN: begin
                cnt_next = 3'h0;
                if (brk_take) begin
                    state_next = ST_PUSH;
                    vec_next = brk_vec;
                    brk_next = 1'b1;
                end else if (irq_take) begin
                    state_next = ST_PUSH;
                    vec_next = irq_vec;
                    id_next = irq_id;
                end else if (ret_go) begin
                    state_next = ST_PULL;
                end else if (wait_op) begin
                    state_next = ST_WAIT;
                end else if (stop_op) begin
                    state_next = ST_STOP;
                end
            end
            ST_PUSH: begin
                cnt_next = cnt_reg + 3'h1;
                if (last_byte) begin
                    state_next = ST_IVEC_HI;
                end
            end
            ST_IVEC_HI: state_next = ST_IVEC_LO;
            ST_IVEC_LO: state_next = ST_RUN;
            ST_PULL: begin
                cnt_next = cnt_reg + 3'h1;
                if (rebreak) begin
                    state_next = ST_PUSH;
                    cnt_next = 3'h0;
                    vec_next = brk_vec;
                end else if (last_byte) begin
                    state_next = ST_RUN;
                    brk_next = 1'b0;
                end
            end
            ST_WAIT: begin
                if (irq_any) begin
                    state_next = ST_PUSH;
                    vec_next = irq_vec;
                    id_next = irq_id;
                end
            end
            ST_STOP: begin
                stab_next = STAB_CYCLES - 13'h1;
                if (irq_req[IRQ_EXT]) begin
                    state_next = ST_STAB;
                    vec_next = irq_vec;
                    id_next = irq_id;
                end
            end
            ST_STAB: begin
                stab_next = stab_reg - 13'h1;
                if (stab_reg == 13'h0) begin
                    state_next = ST_PUSH;
                end
            end
            default: state_next = ST_VEC_HI;
        endcase
    end

    // Register next values; sequencer beats the bus on a clash
    always_comb begin
        a_next = a_reg;
        h_next = h_reg;
        x_next = x_reg;
        sp_next = sp_reg;
        pc_next = pc_reg;
        flg_next = flg_reg;
        case (state_reg)
            ST_VEC_HI: pc_next[15:8] = mem_rdata;
            ST_VEC_LO: pc_next[7:0] = mem_rdata;
            ST_IVEC_HI: pc_next[15:8] = mem_rdata;
            ST_IVEC_LO: pc_next[7:0] = mem_rdata;
            ST_PUSH: begin
                sp_next = sp_reg - 16'h0001;
                if (last_byte) begin
                    flg_next[FLG_I] = 1'b1;
                end
            end
            ST_PULL: begin
                sp_next = sp_reg + 16'h0001;
                case (cnt_reg)
                    3'h0: flg_next = mem_rdata & ~FLG_FIXED;
                    3'h1: a_next = mem_rdata;
                    3'h2: x_next = mem_rdata;
                    3'h3: pc_next[15:8] = mem_rdata;
                    default: pc_next[7:0] = mem_rdata;
                endcase
            end
            ST_RUN: begin
                if (a_we) begin
                    a_next = a_wd;
                end else if (alu_go && alu_to_a) begin
                    a_next = fu_res;
                end else if (wr_a) begin
                    a_next = avs_writedata[7:0];
                end
                if (h_we || x_we) begin
                    h_next = h_we ? h_wd : h_reg;
                    x_next = x_we ? x_wd : x_reg;
                end else if (wr_hx) begin
                    {h_next, x_next} = avs_writedata[15:0];
                end
                if (sp_we) begin
                    sp_next = sp_wd;
                end else if (sp_low_preset) begin
                    sp_next[7:0] = SP_LOW_PRESET;
                end else if (run_push) begin
                    sp_next = sp_reg - 16'h0001;
                end else if (run_pull) begin
                    sp_next = sp_reg + 16'h0001;
                end else if (wr_sp) begin
                    sp_next = avs_writedata[15:0];
                end
                if (pc_we) begin
                    pc_next = pc_wd;
                end else if (pc_inc) begin
                    pc_next = pc_reg + 16'h0001;
                end else if (wr_pc) begin
                    pc_next = avs_writedata[15:0];
                end
                if (flag_we) begin
                    flg_next = flag_wd & ~FLG_FIXED;
                end else if (alu_go) begin
                    // Only the enabled flags change
                    flg_next[FLG_V] = flag_en[FLG_V] ? fu_v : flg_reg[FLG_V];
                    flg_next[FLG_H] = flag_en[FLG_H] ? fu_h : flg_reg[FLG_H];
                    flg_next[FLG_N] = flag_en[FLG_N] ? fu_n : flg_reg[FLG_N];
                    flg_next[FLG_Z] = flag_en[FLG_Z] ? fu_z : flg_reg[FLG_Z];
                    flg_next[FLG_C] = flag_en[FLG_C] ? fu_c : flg_reg[FLG_C];
                end else if (wr_flg) begin
                    flg_next = avs_writedata[7:0] & ~FLG_FIXED;
                end
                if (mask_clear_op || (!brk_take && !irq_take && !ret_go
                    && (wait_op || stop_op))) begin
                    flg_next[FLG_I] = 1'b0;
                end else if (mask_set_op) begin
                    flg_next[FLG_I] = 1'b1;
                end
            end
            default: flg_next = flg_reg;
        endcase
    end

    // Reset presets; the mask comes up set
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_VEC_HI;
            a_reg <= 8'h00;
            h_reg <= 8'h00;
            x_reg <= 8'h00;
            sp_reg <= SP_RESET;
            pc_reg <= 16'h0000;
            flg_reg <= FLG_RESET;
        end else begin
            state_reg <= state_next;
            a_reg <= a_next;
            h_reg <= h_next;
            x_reg <= x_next;
            sp_reg <= sp_next;
            pc_reg <= pc_next;
            flg_reg <= flg_next;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 3'h0;
            stab_reg <= 13'h0000;
            vec_reg <= 16'h0000;
            id_reg <= 3'h0;
            brk_reg <= 1'b0;
            pull_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_next;
            stab_reg <= stab_next;
            vec_reg <= vec_next;
            id_reg <= id_next;
            brk_reg <= brk_next;
            pull_reg <= run_pull ? mem_rdata : pull_reg;
        end
    end

    // One stall cycle per access keeps read data registered
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            acc_reg <= bus_req && !acc_reg;
            if (avs_read && !acc_reg) begin
                case (avs_address)
                    IDX_WORK: rdata_reg <= {24'h000000, a_reg};
                    IDX_INDEX: rdata_reg <= {16'h0000, h_reg, x_reg};
                    IDX_STACK: rdata_reg <= {16'h0000, sp_reg};
                    IDX_FETCH: rdata_reg <= {16'h0000, pc_reg};
                    IDX_FLAG: rdata_reg <= {24'h000000, flg_rd};
                    IDX_STATUS: rdata_reg <= {24'h000000, 3'h0, !run,
                        state_reg == ST_STAB, state_reg == ST_STOP,
                        state_reg == ST_WAIT, brk_reg};
                    default: rdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign avs_waitrequest = bus_req && !acc_reg;
    assign avs_readdata = rdata_reg;
    assign a_q = a_reg;
    assign hx_q = {h_reg, x_reg};
    assign sp_q = sp_reg;
    assign pc_q = pc_reg;
    assign flag_q = flg_rd;
    assign alu_res = fu_res;
    assign stk_rdata = pull_reg;
    assign signed_lt = flg_reg[FLG_N] ^ flg_reg[FLG_V];
    assign signed_le = flg_reg[FLG_Z] | signed_lt;
    assign busy = !run;
    assign cpu_clk_en = !((state_reg == ST_WAIT) || (state_reg == ST_STOP)
        || (state_reg == ST_STAB));
    assign ir_trap_load = run && brk_take || rebreak;
    assign in_break = brk_reg;
    assign irq_ack = (state_reg == ST_IVEC_HI) && !brk_reg;
    assign irq_ack_id = id_reg;
endmodule

// ### design/cpr_pkg.sv
/*
 * Shared constants and types of the CPU programmer register block.
 * Assumes one 20 MHz clock; memory read data is valid in the same
 * cycle as the address.
 */
package cpr_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam logic [15:0] SP_RESET = 16'h00FF;
    localparam logic [7:0] SP_LOW_PRESET = 8'hFF;
    localparam logic [15:0] VEC_RESET_HI = 16'hFFFE;
    localparam logic [15:0] VEC_RESET_LO = 16'hFFFF;
    localparam logic [15:0] VEC_BREAK = 16'hFFFC;
    localparam logic [15:0] VEC_BREAK_MON = 16'hFEFC;
    localparam logic [15:0] VEC_IRQ_TOP = 16'hFFFA;
    localparam int unsigned NUM_IRQ = 8;
    localparam int unsigned IRQ_EXT = 0;
    localparam logic [12:0] STAB_CYCLES = 13'h1000;
    localparam logic [2:0] STACK_BYTES = 3'h5;
    // Flag word bit positions
    localparam int unsigned FLG_V = 7;
    localparam int unsigned FLG_H = 4;
    localparam int unsigned FLG_I = 3;
    localparam int unsigned FLG_N = 2;
    localparam int unsigned FLG_Z = 1;
    localparam int unsigned FLG_C = 0;
    localparam logic [7:0] FLG_FIXED = 8'h60;
    localparam logic [7:0] FLG_RESET = 8'h68;
    // Register word indices on the bus
    localparam logic [2:0] IDX_WORK = 3'h0;
    localparam logic [2:0] IDX_INDEX = 3'h1;
    localparam logic [2:0] IDX_STACK = 3'h2;
    localparam logic [2:0] IDX_FETCH = 3'h3;
    localparam logic [2:0] IDX_FLAG = 3'h4;
    localparam logic [2:0] IDX_STATUS = 3'h5;

    typedef enum logic [3:0] {
        ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_AND, ALU_OR, ALU_EOR,
        ALU_PASS, ALU_SHL, ALU_ROL, ALU_SHR, ALU_ROR, ALU_ASR, ALU_DAA
    } cpr_alu_op_t;

    typedef enum logic [3:0] {
        ST_VEC_HI, ST_VEC_LO, ST_RUN, ST_PUSH, ST_IVEC_HI, ST_IVEC_LO,
        ST_PULL, ST_WAIT, ST_STOP, ST_STAB
    } cpr_state_t;
endpackage

// ### design/cpr_flag_unit.sv
/*
 * Eight-bit arithmetic unit with its condition flags.
 * Purely combinational; the caller decides which flags to keep.
 */
`timescale 1ns/10ps
module cpr_flag_unit import cpr_pkg::*; (
    input wire logic [7:0] opa, // First operand
    input wire logic [7:0] opb, // Second operand
    input wire logic cin, // Carry flag in
    input wire logic hin, // Half-carry flag in
    input wire cpr_alu_op_t op, // Operation
    output logic [7:0] res, // Result
    output logic v, // Overflow
    output logic h, // Half carry
    output logic n, // Negative
    output logic z, // Zero
    output logic c // Carry or borrow
);
    logic [8:0] wide;
    logic [4:0] low;
    logic cuse;
    logic [7:0] adj;

    always_comb begin
        wide = 9'h000;
        low = 5'h00;
        adj = 8'h00;
        cuse = (op == ALU_ADC || op == ALU_SBC) ? cin : 1'b0;
        res = opa;
        v = 1'b0;
        h = hin;
        c = cin;
        case (op)
            ALU_ADD, ALU_ADC: begin
                wide = {1'b0, opa} + {1'b0, opb} + {8'h00, cuse};
                low = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cuse};
                res = wide[7:0];
                c = wide[8];
                h = low[4];
                v = (opa[7] == opb[7]) && (res[7] != opa[7]);
            end
            ALU_SUB, ALU_SBC: begin
                wide = {1'b0, opa} - {1'b0, opb} - {8'h00, cuse};
                res = wide[7:0];
                c = wide[8];
                v = (opa[7] != opb[7]) && (res[7] != opa[7]);
            end
            ALU_AND: res = opa & opb;
            ALU_OR: res = opa | opb;
            ALU_EOR: res = opa ^ opb;
            ALU_PASS: res = opb;
            ALU_SHL, ALU_ROL: begin
                res = {opa[6:0], (op == ALU_ROL) ? cin : 1'b0};
                c = opa[7];
                v = res[7] ^ opa[7];
            end
            ALU_SHR, ALU_ROR, ALU_ASR: begin
                res = {(op == ALU_ROR) ? cin : ((op == ALU_ASR) ? opa[7] : 1'b0),
                    opa[7:1]};
                c = opa[0];
                v = res[7] ^ opa[0];
            end
            ALU_DAA: begin
                // Correction chosen from half carry and carry
                adj[3:0] = (hin || opa[3:0] > 4'h9) ? 4'h6 : 4'h0;
                adj[7:4] = (cin || opa > 8'h99) ? 4'h6 : 4'h0;
                res = opa + adj;
                c = cin || (opa > 8'h99);
            end
            default: res = opa;
        endcase
        n = res[7];
        z = (res == 8'h00);
    end
endmodule

// ### tb/cpr_regs_asserts.sv
/* Port checker for cpr_regs.
   Bound from the bench top; sees only the design's ports. */
`timescale 1ns/10ps
module cpr_regs_asserts import cpr_pkg::*; (
    input wire logic clk, // Clock
    input wire logic rst, // Reset
    input wire logic [7:0] flag_q, // Flags
    input wire logic [15:0] sp_q, // Stack
    input wire logic [15:0] mem_addr, // Address
    input wire logic sp_low_preset, // Preset
    input wire logic stk_push, // Push
    input wire logic stk_pull, // Pull
    input wire logic sp_we, // Stack write
    input wire logic busy, // Busy
    input wire logic mem_wr, // Write strobe
    input wire logic irq_ack, // Vector read
    input wire logic avs_read, // Bus read
    input wire logic avs_write, // Bus write
    input wire logic avs_waitrequest // Stall
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Other writers of the stack pointer are kept out of the antecedents
    wire quiet = !busy && !sp_we && !avs_write;
    chk_fixed_ones:
    assert property (flag_q[6:5] == 2'b11) else $error("fixed bits");
    chk_low_preset:
    assert property (sp_low_preset && !stk_push && !stk_pull && quiet
        |=> sp_q == (16'h00FF | $past(sp_q))) else $error("preset");
    chk_push_dec:
    assert property (stk_push && !sp_low_preset && quiet |=> sp_q == $past(sp_q) - 16'h1)
        else $error("push");
    chk_push_addr:
    assert property (stk_push && !busy |-> mem_wr && mem_addr == sp_q) else $error("push addr");
    chk_wr_cause:
    assert property (mem_wr && !busy |-> stk_push) else $error("stray write");
    chk_mask_vec:
    assert property (irq_ack |-> flag_q[FLG_I]) else $error("mask late");
    chk_reset_state:
    assert property ($fell(rst) |-> sp_q == SP_RESET && flag_q[FLG_I]) else $error("reset");
    chk_bus_wait:
    assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait");
endmodule

// ### tb/cpr_mem_model.sv
/* Memory beside cpr_regs: 256-byte RAM on every page but the top, vectors at the top page.
   Assumes reads are combinational, writes on the clock. */
`timescale 1ns/10ps
module cpr_mem_model (
    input wire logic clk, // Clock
    input wire logic [15:0] mem_addr, // Address
    input wire logic mem_rd, // Read
    input wire logic mem_wr, // Write
    input wire logic [7:0] mem_wdata, // Write data
    output logic [7:0] mem_rdata // Read data
);
    logic [7:0] ram [0:255];
    logic [7:0] last_reg = 8'h00;
    wire [7:0] word = (mem_addr[15:8] == 8'hFF) ? mem_addr[7:0] ^ 8'h5A : ram[mem_addr[7:0]];
    // Idle bus shows the inverse, so a stale byte is never taken
    assign mem_rdata = mem_rd ? word : ~last_reg;
    always_ff @(posedge clk) begin
        if (mem_wr) ram[mem_addr[7:0]] <= mem_wdata;
        if (mem_rd) last_reg <= word;
    end
endmodule

// ### tb/cpr_regs_test.sv
/* Bench top for cpr_regs with memory model and bound checker.
   Assumes nothing outside; runs on its own. */
`timescale 1ns/10ps
module cpr_regs_test import cpr_pkg::*;;
    logic clk = 0, rst = 1, a_we = 0, h_we = 0, x_we = 0, sp_we = 0, sp_low_preset = 0;
    logic pc_we = 0, pc_inc = 0, alu_go = 0, alu_to_a = 0, flag_we = 0, mask_clear_op = 0;
    logic mask_set_op = 0, stk_push = 0, stk_pull = 0, instr_done = 0, interrupt_return_op = 0;
    logic wait_op = 0, stop_op = 0, brk_req = 0, brk_match = 0, monitor_mode = 0, avs_read = 0;
    logic avs_write = 0, mem_rd, mem_wr, signed_lt, signed_le, busy, cpu_clk_en, ir_trap_load;
    logic in_break, irq_ack, avs_waitrequest;
    logic [7:0] a_wd = '0, h_wd = '0, x_wd = '0, alu_a = '0, alu_b = '0, flag_en = '0;
    logic [7:0] flag_wd = '0, stk_wdata = '0, irq_req = '0, mem_rdata, mem_wdata, a_q, flag_q;
    logic [7:0] alu_res, stk_rdata;
    logic [15:0] sp_wd = '0, pc_wd = '0, mem_addr, hx_q, sp_q, pc_q, p;
    logic [2:0] avs_address = '0, irq_ack_id;
    logic [31:0] avs_writedata = '0, avs_readdata, rd;
    logic [15:0] corners [3] = '{16'h7F01, 16'h0F01, 16'hFF01};
    cpr_alu_op_t alu_op = ALU_ADD;
    int num_errors = 0, checks_done = 0;
    always #25 clk = ~clk;
    cpr_regs cpr_regs_inst (.*);
    cpr_mem_model cpr_mem_model_inst (.*);
    task step;
        @(posedge clk);
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wrap_up;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task bus(input logic w, input logic [2:0] ad, input logic [31:0] wd);
        step;
        avs_address <= ad;
        avs_writedata <= wd;
        avs_read <= !w;
        avs_write <= w;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // Expected {result, flags} of an add with the mask still set
    function logic [15:0] add_exp(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = 9'(a) + 9'(b);
        return {s[7:0], a[7] == b[7] && s[7] != a[7], 2'b11,
            (5'(a[3:0]) + 5'(b[3:0])) > 5'h0F, 1'b1, s[7], s[7:0] == 8'h00, s[8]};
    endfunction
    initial begin
        void'($urandom(32'h337F));
        repeat (16) step;
        rst <= 1'b0;
        do @(negedge clk); while (busy !== 1'b0);
        chk(pc_q, 16'hA4A5);
        chk(flag_q, 8'h68);
        bus(0, IDX_STACK, '0);
        chk(rd, 32'h00FF);
        bus(1, IDX_INDEX, 32'hFFFF_5AC3);
        bus(0, IDX_INDEX, '0);
        chk(rd, 32'h5AC3);
        bus(0, 3'h6, '0);
        chk(rd, '0);
        bus(1, IDX_STACK, 32'h12A0);
        sp_low_preset <= 1'b1;
        step;
        sp_low_preset <= 1'b0;
        stk_push <= 1'b1;
        stk_wdata <= 8'hC3;
        repeat (2) step;
        stk_push <= 1'b0;
        stk_pull <= 1'b1;
        step;
        stk_pull <= 1'b0;
        @(negedge clk);
        chk(sp_q, 16'h12FE);
        chk(stk_rdata, 8'hC3);
        for (int i = 0; i < 24; i++) begin
            step;
            p = i < 3 ? corners[i] : 16'($urandom);
            alu_a <= p[15:8];
            alu_b <= p[7:0];
            alu_go <= 1'b1;
            alu_to_a <= 1'b1;
            flag_en <= 8'h97;
            step;
            alu_go <= 1'b0;
            @(negedge clk);
            rd[15:0] = add_exp(p[15:8], p[7:0]);
            chk(a_q, rd[15:8]);
            chk(flag_q, rd[7:0]);
        end
        step;
        mask_clear_op <= 1'b1;
        step;
        mask_clear_op <= 1'b0;
        irq_req <= 8'h06;
        instr_done <= 1'b1;
        step;
        instr_done <= 1'b0;
        do @(negedge clk); while (busy !== 1'b0);
        chk(pc_q, 16'hA2A3);
        chk(irq_ack_id, 3'h1);
        chk(sp_q, 16'h12F9);
        chk(flag_q & 8'h08, 8'h08);
        step;
        interrupt_return_op <= 1'b1;
        step;
        interrupt_return_op <= 1'b0;
        do @(negedge clk); while (busy !== 1'b0);
        chk({sp_q, pc_q}, 32'h12FE_A4A5);
        chk(flag_q & 8'h08, 8'h00);
        wrap_up;
    end
    initial begin
        #100_000;
        num_errors++;
        wrap_up;
    end
endmodule
bind cpr_regs cpr_regs_asserts cpr_regs_asserts_inst (.*);
